// file: rtl/irq_pending_regs.vh
// register map and constants for the pending set/clear register block
// assumes a 32-bit apb slave on a 25 mhz clock with synchronous active-high reset
// How it works
// - force register bits 31..3 pend interrupts 127..99, bit 0 pends 96; bits 2..1 write zero.
// - a one written to a force bit makes that interrupt pending.
// - a force one does nothing when already pending or disabled.
// - writing zero to any force or drop bit changes nothing.
// - reading any force or drop bit returns the current pending state.
// - pending raised by a force bit is removed by its drop bit.
// - drop register bits 31..16 and 13..0 clear interrupts 31..16 and 13..0.
// - a drop one does nothing while the interrupt is in service.
`ifndef IRQ_PENDING_REGS_VH
`define IRQ_PENDING_REGS_VH

`define OFF_FORCE_HI    8'h00
`define OFF_DROP_LO     8'h04
`define OFF_DROP_HI     8'h08
`define OFF_EVT_STATUS  8'h0C
`define OFF_EVT_MASK    8'h10
`define ADDR_W          8

`define VALID_HI        32'hFFFFFFF9
`define VALID_LO        32'hFFFF3FFF
`define RSVD_HI         32'h00000006
`define RSVD_LO         32'h0000C000

`define EVT_W           3
`define EVT_NEW_HI      0
`define EVT_NEW_LO      1
`define EVT_RSVD_WR     2
`define EVT_ZERO        3'h0
`define MASK_RESET      3'h0
`define WORD_ZERO       32'h00000000

`endif

// file: rtl/pending_bank.v
// one bank of 32 pending flags, only bits present in VALID get a flop
// assumes source, enable, service and acknowledge come from logic on the same clock
`timescale 1ns/10ps
module pending_bank #(
   parameter [31:0] VALID = 32'hFFFFFFFF
)(
   input  wire        clk,
   input  wire        rst,
   input  wire        ce,
   input  wire [31:0] force_wr,
   input  wire [31:0] drop_wr,
   input  wire [31:0] src,
   input  wire [31:0] ack,
   input  wire [31:0] en,
   input  wire [31:0] act,
   output wire [31:0] pend,
   output reg         new_pend_q
);
   wire [31:0] pend_d;
   genvar i;
   generate
      for (i = 0; i < 32; i = i + 1)
      begin : g_bit
         if (VALID[i])
         begin : g_on
            reg  pend_q;
            wire set_b;
            wire clr_b;
            // software force only on an enabled, idle interrupt; source always latches
            assign set_b = (force_wr[i] & en[i] & ~pend_q) | src[i];
            // drop ignored while in service; acknowledge clears on entry to service
            assign clr_b = (drop_wr[i] & ~act[i]) | ack[i];
            assign pend_d[i] = set_b ? 1'b1 : (clr_b ? 1'b0 : pend_q);
            always @(posedge clk)
            begin
               if (rst)
                  pend_q <= 1'b0;
               else if (ce)
                  pend_q <= pend_d[i];
            end
            assign pend[i] = pend_q;
         end
         else
         begin : g_off
            assign pend_d[i] = 1'b0;
            assign pend[i]   = 1'b0;
         end
      end
   endgenerate

   always @(posedge clk)
   begin
      if (rst)
         new_pend_q <= 1'b0;
      else if (ce)
         new_pend_q <= |(pend_d & ~pend);
   end
endmodule

// file: rtl/evt_status.v
// sticky event flags cleared by read, with a mask and one level interrupt
// assumes clear vector holds only bits that the read actually returned
`timescale 1ns/10ps
`include "irq_pending_regs.vh"
module evt_status (
   input  wire              clk,
   input  wire              rst,
   input  wire              ce,
   input  wire [`EVT_W-1:0] evt,
   input  wire [`EVT_W-1:0] rd_clr,
   input  wire              mask_we,
   input  wire [`EVT_W-1:0] mask_d,
   output reg  [`EVT_W-1:0] status_q,
   output reg  [`EVT_W-1:0] mask_q,
   output reg               irq_q
);
   wire [`EVT_W-1:0] status_d;
   // a new event wins over the read clear in the same cycle
   assign status_d = (status_q & ~rd_clr) | evt;

   always @(posedge clk)
   begin
      if (rst)
      begin
         status_q <= `EVT_ZERO;
         mask_q   <= `MASK_RESET;
         irq_q    <= 1'b0;
      end
      else if (ce)
      begin
         status_q <= status_d;
         if (mask_we)
            mask_q <= mask_d;
         irq_q <= |(status_d & (mask_we ? mask_d : mask_q));
      end
   end
endmodule

// file: rtl/irq_pending_set_clear_regs.v
// apb register block for forcing and dropping interrupt pending state
// assumes enable, in-service, source and acknowledge vectors arrive on clk
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/10ps
`include "irq_pending_regs.vh"
module irq_pending_set_clear_regs (
   input  wire                 clk,
   input  wire                 rst,
   input  wire                 ce,
   input  wire                 psel,
   input  wire                 penable,
   input  wire                 pwrite,
   input  wire [`ADDR_W-1:0]   paddr,
   input  wire [31:0]          pwdata,
   input  wire [3:0]           pstrb,
   output wire                 pready,
   output reg  [31:0]          prdata,
   output reg                  pslverr,
   input  wire [31:0]          en_hi,
   input  wire [31:0]          act_hi,
   input  wire [31:0]          src_hi,
   input  wire [31:0]          ack_hi,
   input  wire [31:0]          en_lo,
   input  wire [31:0]          act_lo,
   input  wire [31:0]          src_lo,
   input  wire [31:0]          ack_lo,
   output wire [31:0]          pend_hi,
   output wire [31:0]          pend_lo,
   output wire                 irq
);
   function hit;
      input [`ADDR_W-1:0] a;
      input [`ADDR_W-1:0] off;
      begin
         hit = (a == off);
      end
   endfunction

   function [31:0] lanes;
      input [3:0] s;
      begin
         lanes = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
      end
   endfunction

   wire        setup_ph;
   wire        access_ph;
   wire        wr_fire;
   wire        rd_fire;
   wire [31:0] wmask;
   wire        mapped;
   wire [31:0] force_hi_wr;
   wire [31:0] drop_hi_wr;
   wire [31:0] drop_lo_wr;
   wire [`EVT_W-1:0] evt;
   wire [`EVT_W-1:0] rd_clr;
   wire [`EVT_W-1:0] status;
   wire [`EVT_W-1:0] mask;
   wire        new_hi;
   wire        new_lo;
   wire        rsvd_wr;
   wire        mask_we;
   reg  [31:0] rd_d;
   reg         stat_rd_q;

   assign setup_ph  = psel & ~penable;
   assign access_ph = psel & penable;
   // zero wait states: read data is captured in the setup cycle
   assign pready    = access_ph;
   assign wr_fire   = access_ph & pwrite & ce;
   assign rd_fire   = access_ph & ~pwrite & ce;
   assign wmask     = pwdata & lanes(pstrb);
   assign mapped    = hit(paddr, `OFF_FORCE_HI) | hit(paddr, `OFF_DROP_LO) |
                      hit(paddr, `OFF_DROP_HI) | hit(paddr, `OFF_EVT_STATUS) |
                      hit(paddr, `OFF_EVT_MASK);

   // zero bits leave state alone; unused bit positions are never decoded
   assign force_hi_wr = (wr_fire & hit(paddr, `OFF_FORCE_HI)) ?
                        (wmask & `VALID_HI) : `WORD_ZERO;
   assign drop_lo_wr  = (wr_fire & hit(paddr, `OFF_DROP_LO)) ?
                        (wmask & `VALID_LO) : `WORD_ZERO;
   assign drop_hi_wr  = (wr_fire & hit(paddr, `OFF_DROP_HI)) ?
                        (wmask & `VALID_HI) : `WORD_ZERO;
   // flag writes of one to positions that must be written as zero, in the force and low drop registers only
   assign rsvd_wr = (wr_fire & hit(paddr, `OFF_FORCE_HI) & (|(wmask & `RSVD_HI))) |
                    (wr_fire & hit(paddr, `OFF_DROP_LO) & (|(wmask & `RSVD_LO)));
   assign mask_we = wr_fire & hit(paddr, `OFF_EVT_MASK);

   pending_bank #(
      .VALID (`VALID_HI)
   ) u_bank_hi (
      .clk        (clk),
      .rst        (rst),
      .ce         (ce),
      .force_wr   (force_hi_wr),
      .drop_wr    (drop_hi_wr),
      .src        (src_hi),
      .ack        (ack_hi),
      .en         (en_hi),
      .act        (act_hi),
      .pend       (pend_hi),
      .new_pend_q (new_hi)
   );

   pending_bank #(
      .VALID (`VALID_LO)
   ) u_bank_lo (
      .clk        (clk),
      .rst        (rst),
      .ce         (ce),
      .force_wr   (`WORD_ZERO),
      .drop_wr    (drop_lo_wr),
      .src        (src_lo),
      .ack        (ack_lo),
      .en         (en_lo),
      .act        (act_lo),
      .pend       (pend_lo),
      .new_pend_q (new_lo)
   );

   assign evt[`EVT_NEW_HI]  = new_hi;
   assign evt[`EVT_NEW_LO]  = new_lo;
   assign evt[`EVT_RSVD_WR] = rsvd_wr;
   // clear only what the completed read returned
   assign rd_clr = (rd_fire & stat_rd_q) ? prdata[`EVT_W-1:0] : `EVT_ZERO;

   evt_status u_evt (
      .clk      (clk),
      .rst      (rst),
      .ce       (ce),
      .evt      (evt),
      .rd_clr   (rd_clr),
      .mask_we  (mask_we),
      .mask_d   (wmask[`EVT_W-1:0]),
      .status_q (status),
      .mask_q   (mask),
      .irq_q    (irq)
   );

   always @*
   begin
      rd_d = `WORD_ZERO;
      case (paddr)
         `OFF_FORCE_HI:   rd_d = pend_hi;
         `OFF_DROP_HI:    rd_d = pend_hi;
         `OFF_DROP_LO:    rd_d = pend_lo;
         `OFF_EVT_STATUS: rd_d = {{(32-`EVT_W){1'b0}}, status};
         `OFF_EVT_MASK:   rd_d = {{(32-`EVT_W){1'b0}}, mask};
         default:         rd_d = `WORD_ZERO;
      endcase
   end

   always @(posedge clk)
   begin
      if (rst)
      begin
         prdata    <= `WORD_ZERO;
         pslverr   <= 1'b0;
         stat_rd_q <= 1'b0;
      end
      else if (ce & setup_ph)
      begin
         prdata    <= pwrite ? `WORD_ZERO : rd_d;
         pslverr   <= ~mapped;
         stat_rd_q <= ~pwrite & hit(paddr, `OFF_EVT_STATUS);
      end
   end
endmodule

// file: verif/irq_pending_properties.sv
// concurrent checks on the pending set/clear register block
// assumes a bind to the block top; sees only its ports
`timescale 1ns/10ps
module irq_pending_properties (
   input wire        clk,
   input wire        rst,
   input wire        ce,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire [3:0]  pstrb,
   input wire [31:0] prdata,
   input wire [31:0] en_hi,
   input wire [31:0] act_hi,
   input wire [31:0] src_hi,
   input wire [31:0] ack_hi,
   input wire [31:0] act_lo,
   input wire [31:0] src_lo,
   input wire [31:0] ack_lo,
   input wire [31:0] pend_hi,
   input wire [31:0] pend_lo
);
   wire wr = psel & penable & pwrite & ce;
   default clocking @(posedge clk);
   endclocking
   default disable iff (rst);
   chk_force_sets:
   assert property (wr && paddr == 8'h00 && pstrb[3] && pwdata[31] && en_hi[31] |=> pend_hi[31]) else $error("no set");
   chk_force_disabled:
   assert property (!en_hi[30] && !pend_hi[30] && !src_hi[30] |=> !pend_hi[30]) else $error("set while off");
   chk_zero_keeps:
   assert property (pend_hi[3] && !ack_hi[3] && !(wr && paddr == 8'h08) |=> pend_hi[3]) else $error("lost");
   chk_gap_zero:
   assert property (pend_hi[2:1] == 2'b00 && pend_lo[15:14] == 2'b00) else $error("gap bit set");
   chk_read_state:
   assert property (psel && !penable && !pwrite && ce && paddr == 8'h04 |=> prdata == $past(pend_lo))
   else $error("read wrong");
   chk_drop_clears:
   assert property (wr && paddr == 8'h04 && pstrb[2] && pwdata[16] && !act_lo[16] && !src_lo[16] |=> !pend_lo[16])
   else $error("no drop");
   chk_drop_in_service:
   assert property (pend_lo[5] && act_lo[5] && !ack_lo[5] |=> pend_lo[5]) else $error("dropped in service");
   chk_drop_hi:
   assert property (wr && paddr == 8'h08 && pstrb[0] && pwdata[0] && !act_hi[0] && !src_hi[0] |=> !pend_hi[0])
   else $error("no hi drop");
endmodule

// file: verif/irq_pending_set_clear_regs_tb.sv
// self-checking bench for the pending set/clear register block
// assumes zero wait state apb answers
`timescale 1ns/10ps
`include "irq_pending_regs.vh"
module irq_pending_set_clear_regs_tb;
   reg         clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ce = 1'b1;
   reg  [3:0]  pstrb = 4'hF;
   reg  [7:0]  paddr = 8'h00;
   reg  [31:0] pwdata = 32'h0, en_hi = 32'h0, act_hi = 32'h0, src_hi = 32'h0, ack_hi = 32'h0;
   reg  [31:0] en_lo = 32'h0, act_lo = 32'h0, src_lo = 32'h0, ack_lo = 32'h0, r1, r2, r3, p;
   reg  [33:0] expq[$];
   reg  [33:0] e;
   wire        pready, pslverr, irq;
   wire [31:0] prdata, pend_hi, pend_lo;
   integer     failures = 0, cmp_count = 0, cyc = 0;
   irq_pending_set_clear_regs i_irq_pending_set_clear_regs (
      .clk     (clk),
      .rst     (rst),
      .ce      (ce),
      .psel    (psel),
      .penable (penable),
      .pwrite  (pwrite),
      .paddr   (paddr),
      .pwdata  (pwdata),
      .pstrb   (pstrb),
      .pready  (pready),
      .prdata  (prdata),
      .pslverr (pslverr),
      .en_hi   (en_hi),
      .act_hi  (act_hi),
      .src_hi  (src_hi),
      .ack_hi  (ack_hi),
      .en_lo   (en_lo),
      .act_lo  (act_lo),
      .src_lo  (src_lo),
      .ack_lo  (ack_lo),
      .pend_hi (pend_hi),
      .pend_lo (pend_lo),
      .irq     (irq)
   );
   always #20 clk = ~clk;
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task wrap_up;
      begin
         $display("compares %0d mismatches %0d", cmp_count, failures);
         if (failures == 0 && cmp_count > 0)
            $display("RESULT: PASS");
         else
            $display("RESULT: FAIL");
         $finish;
      end
   endtask
   task xfer(input [7:0] a, input w, input [31:0] d);
      begin
         @(posedge clk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge clk);
         penable <= 1'b1;
         @(posedge clk);
         while (!pready)
            @(posedge clk);
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // expectation is {slave error, irq, read data}
   task rd(input [7:0] a, input [31:0] d, input i);
      begin
         expq.push_back({a > 8'h10, i, (a > 8'h10) ? 32'h0 : d});
         xfer(a, 1'b0, 32'h0);
      end
   endtask
   // one process owns the compare and the timeout, so failures has a single writer
   always @(posedge clk)
   begin
      cyc = cyc + 1;
      if (psel && penable && pready && !pwrite)
      begin
         e = expq.pop_front();
         cmp_count = cmp_count + 1;
         if ({pslverr, irq, prdata} !== e)
         begin
            failures = failures + 1;
            $display("BAD read %h expected %h seen %h", paddr, e, {pslverr, irq, prdata});
         end
      end
      if (cyc == 3000)
      begin
         failures = failures + 1;
         wrap_up;
      end
   end
   initial
   begin
      r1 = lfsr(32'h00013735) | 32'h80000001;
      r2 = lfsr(r1) | 32'h80000007;
      r3 = lfsr(r2) & 32'hFFFEFFFF | 32'h00000020;
      p = r1 & r2 & `VALID_HI;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      xfer(8'h04, 1'b1, `VALID_LO);
      xfer(8'h08, 1'b1, `VALID_HI);
      rd(8'h00, 32'h0, 1'b0);
      rd(8'h10, 32'h0, 1'b0);
      xfer(8'h20, 1'b1, 32'hFFFFFFFF);
      rd(8'h20, 32'h0, 1'b0);
      $display("test reset done");
      xfer(8'h00, 1'b1, 32'hFFFFFFFF);
      rd(8'h00, 32'h0, 1'b0);
      en_hi <= r1;
      xfer(8'h00, 1'b1, r2);
      rd(8'h00, p, 1'b0);
      xfer(8'h00, 1'b1, 32'h0);
      xfer(8'h08, 1'b1, 32'h0);
      rd(8'h08, p, 1'b0);
      xfer(8'h08, 1'b1, p & 32'h0000FFFF);
      rd(8'h00, p & 32'hFFFF0000, 1'b0);
      $display("test force done");
      act_lo <= r3;
      src_lo <= 32'hFFFFFFFF;
      @(posedge clk);
      src_lo <= 32'h0;
      xfer(8'h04, 1'b1, 32'hFFFFFFFF);
      rd(8'h04, r3 & `VALID_LO, 1'b0);
      rd(8'h0C, 32'h7, 1'b0);
      rd(8'h0C, 32'h0, 1'b0);
      ack_lo <= 32'hFFFFFFFF;
      ack_hi <= 32'hFFFFFFFF;
      en_hi <= 32'hFFFFFFFF;
      @(posedge clk);
      ack_lo <= 32'h0;
      ack_hi <= 32'h0;
      rd(8'h04, 32'h0, 1'b0);
      // a source pulse while the clock enable is low must leave no trace
      ce <= 1'b0;
      src_lo <= 32'hFFFFFFFF;
      @(posedge clk);
      ce <= 1'b1;
      src_lo <= 32'h0;
      rd(8'h04, 32'h0, 1'b0);
      $display("test drop done");
      xfer(8'h10, 1'b1, 32'h1);
      xfer(8'h00, 1'b1, 32'h8);
      repeat (3) @(posedge clk);
      rd(8'h10, 32'h1, 1'b1);
      rd(8'h0C, 32'h1, 1'b1);
      rd(8'h0C, 32'h0, 1'b0);
      xfer(8'h10, 1'b1, 32'h2);
      xfer(8'h00, 1'b1, 32'h10);
      repeat (3) @(posedge clk);
      rd(8'h0C, 32'h1, 1'b0);
      rd(8'h00, 32'h18, 1'b0);
      // only the low byte lane is written, so only bit 5 may pend
      pstrb <= 4'h1;
      xfer(8'h00, 1'b1, 32'hFFFFFF20);
      pstrb <= 4'hF;
      rd(8'h00, 32'h38, 1'b0);
      $display("test irq done");
      repeat (2) @(posedge clk);
      wrap_up;
   end
endmodule
bind irq_pending_set_clear_regs irq_pending_properties i_irq_pending_properties (
   .clk     (clk),
   .rst     (rst),
   .ce      (ce),
   .psel    (psel),
   .penable (penable),
   .pwrite  (pwrite),
   .paddr   (paddr),
   .pwdata  (pwdata),
   .pstrb   (pstrb),
   .prdata  (prdata),
   .en_hi   (en_hi),
   .act_hi  (act_hi),
   .src_hi  (src_hi),
   .ack_hi  (ack_hi),
   .act_lo  (act_lo),
   .src_lo  (src_lo),
   .ack_lo  (ack_lo),
   .pend_hi (pend_hi),
   .pend_lo (pend_lo)
);
